// file: src/bss_top.sv
// Notes on behaviour
// R1: conversion split, upper/lower widths follow resolution
// R2: with mode select low, bridge powered only during upper stage
// R3: each bridge sample lasts two clocks
// R4: samples equal two^upper times supply ratio
// R5: with mode select low, bridge-on time is samples times two clocks
// R6: ratio setting, four choices, resets to 1/16
// R7: reset input is active high
// R8: serial output driven or released to high-z
// R9: mode select input holds bridge on continuously
// R10: host supplies 8 ms programming pulse externally
// R11: sample counter cleared at start, compared at end
module bss_top #(
    parameter int unsigned DIV = bss_pkg::CONV_DIV
) (
    input  wire logic       I_REF_CLK,
    input  wire logic       I_SYS_RST,
    input  wire logic       I_START,
    input  wire logic [1:0] I_RESOLUTION,
    input  wire logic       I_RATIO_WR,
    input  wire logic [1:0] I_SUPPLY_RATIO_SETTING,
    input  wire logic       I_BRIDGE_MODE_SELECT,
    input  wire logic       I_SDO_DATA,
    input  wire logic       I_SDO_ENABLE,
    output logic            O_BRIDGE_SUPPLY,
    output logic            O_UPPER_STAGE,
    output logic            O_LOWER_STAGE,
    output logic            O_BUSY,
    output logic            O_DONE,
    output logic [3:0]      O_UPPER_WIDTH,
    output logic [3:0]      O_LOWER_WIDTH,
    output logic [1:0]      O_RATIO,
    output logic            O_SDO,
    output logic            O_SDO_OE
);
    typedef struct packed {
        bss_pkg::bss_state_t               state;
        bss_pkg::bss_ratio_t               ratio;
        bss_pkg::bss_ratio_t               run_ratio;
        logic [1:0]                        res;
        logic [bss_pkg::CNT_W-1:0]         smp;
        logic                              phase;
        logic [3:0]                        lcnt;
        logic                              supply;
        logic                              upper;
        logic                              lower;
        logic                              busy;
        logic [3:0]                        uw;
        logic [3:0]                        lw;
        logic                              done;
        logic                              sdo;
        logic                              sdo_oe;
    } bss_st_t;

    bss_st_t st;
    bss_st_t next_st;
    logic    tick;

    // one phase bit per sample: only a two-tick sample fits
    if (bss_pkg::TICKS_PER_SMP != 2) begin : g_tick_check
        $error("bss_top: TICKS_PER_SMP must be 2");
    end
    // largest sample target is 128
    if (bss_pkg::CNT_W < 8) begin : g_cnt_check
        $error("bss_top: CNT_W too narrow");
    end
    if (DIV < 2 || DIV > 65535) begin : g_div_check
        $error("bss_top: DIV out of range");
    end

    function automatic logic [3:0] upper_width(input logic [1:0] res);
        upper_width = 4'(bss_pkg::UPPER_BASE) + {2'b00, res}; // R1
    endfunction : upper_width

    // one less than the upper width at every resolution
    function automatic logic [3:0] lower_width(input logic [1:0] res);
        lower_width = upper_width(res) - 4'h1; // R1
    endfunction : lower_width

    // 2^upper * 2^(ratio-5): always a power of two from 2 to 128
    function automatic logic [bss_pkg::CNT_W-1:0] sample_target(input logic [1:0] res,
                                                                input logic [1:0] ratio);
        logic [3:0] sh;
        sh = upper_width(res) + {2'b00, ratio} - 4'(bss_pkg::RATIO_SHIFT);
        sample_target = bss_pkg::CNT_W'(1) << sh; // R4
    endfunction : sample_target

    bss_tick_div #(
        .DIV (DIV)
    ) u_div (
        .i_clk     (I_REF_CLK),
        .i_rst     (I_SYS_RST),
        .i_restart (I_START && st.state == bss_pkg::BSS_IDLE),
        .o_tick    (tick)
    );

    always_comb begin
        next_st        = st;
        next_st.done   = 1'b0;
        next_st.sdo    = I_SDO_DATA;
        next_st.sdo_oe = I_SDO_ENABLE; // R8
        // setting changes mid-conversion take effect at the next start
        if (I_RATIO_WR) begin
            next_st.ratio = bss_pkg::bss_ratio_t'(I_SUPPLY_RATIO_SETTING); // R6
        end
        case (st.state)
            bss_pkg::BSS_IDLE: begin
                if (I_START) begin
                    next_st.state = bss_pkg::BSS_UPPER;
                    next_st.res   = I_RESOLUTION;
                    // latched so a write while busy cannot overshoot the target
                    next_st.run_ratio = st.ratio;
                    next_st.smp   = '0; // R11
                    next_st.phase = 1'b0;
                end
            end
            bss_pkg::BSS_UPPER: begin
                if (tick) begin
                    next_st.phase = ~st.phase; // R3
                    if (st.phase) begin
                        next_st.smp = st.smp + bss_pkg::CNT_W'(1);
                        if (next_st.smp == sample_target(st.res, st.run_ratio)) begin // R11 R5
                            next_st.state = bss_pkg::BSS_LOWER;
                            next_st.lcnt  = lower_width(st.res);
                        end
                    end
                end
            end
            bss_pkg::BSS_LOWER: begin
                if (tick) begin
                    if (st.lcnt == 4'h1) begin
                        next_st.state = bss_pkg::BSS_IDLE;
                        next_st.done  = 1'b1;
                    end else begin
                        next_st.lcnt = st.lcnt - 4'h1;
                    end
                end
            end
            default: begin
                next_st.state = bss_pkg::BSS_IDLE;
            end
        endcase
        // static bridge mode trades power for settling; switched mode cuts lower stage
        next_st.supply = (next_st.state == bss_pkg::BSS_UPPER) || I_BRIDGE_MODE_SELECT; // R2 R9
        next_st.upper  = (next_st.state == bss_pkg::BSS_UPPER); // R2
        next_st.lower  = (next_st.state == bss_pkg::BSS_LOWER);
        next_st.busy   = (next_st.state != bss_pkg::BSS_IDLE);
        next_st.uw     = upper_width(next_st.res); // R1
        next_st.lw     = lower_width(next_st.res); // R1
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin // R7
            st       <= '0;
            st.ratio <= bss_pkg::RATIO_RESET; // R6
            st.run_ratio <= bss_pkg::RATIO_RESET;
            st.uw    <= 4'(bss_pkg::UPPER_BASE);
            st.lw    <= 4'(bss_pkg::UPPER_BASE) - 4'h1;
        end else begin
            st <= next_st;
        end
    end

    assign O_BRIDGE_SUPPLY = st.supply;
    assign O_UPPER_STAGE   = st.upper;
    assign O_LOWER_STAGE   = st.lower;
    assign O_BUSY          = st.busy;
    assign O_DONE          = st.done;
    assign O_UPPER_WIDTH   = st.uw;
    assign O_LOWER_WIDTH   = st.lw;
    assign O_RATIO         = st.ratio;
    assign O_SDO           = st.sdo;
    assign O_SDO_OE        = st.sdo_oe;
endmodule : bss_top

// file: include/bss_pkg.sv
package bss_pkg;
    localparam int unsigned REF_CLK_HZ    = 10_000_000;
    localparam int unsigned CONV_CLK_HZ   = 32_000;
    localparam int unsigned CONV_DIV      = REF_CLK_HZ / CONV_CLK_HZ;
    localparam int unsigned TICKS_PER_SMP = 2;
    localparam int unsigned CNT_W         = 8;
    localparam int unsigned UPPER_BASE    = 6;
    localparam int unsigned RATIO_SHIFT   = 5;

    typedef enum logic [1:0] {
        BSS_RES_10,
        BSS_RES_12,
        BSS_RES_14,
        BSS_RES_16
    } bss_res_t;

    typedef enum logic [1:0] {
        BSS_RATIO_1_32,
        BSS_RATIO_1_16,
        BSS_RATIO_1_8,
        BSS_RATIO_1_4
    } bss_ratio_t;

    localparam bss_ratio_t RATIO_RESET = BSS_RATIO_1_16;

    typedef enum logic [1:0] {
        BSS_IDLE,
        BSS_UPPER,
        BSS_LOWER
    } bss_state_t;
endpackage : bss_pkg

// file: src/bss_tick_div.sv
module bss_tick_div #(
    parameter int unsigned DIV = bss_pkg::CONV_DIV
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_restart,
    output logic      o_tick
);
    // counter is sixteen bits and a tick needs at least two states
    if (DIV < 2 || DIV > 65535) begin : g_div_range
        $error("bss_tick_div: DIV out of range");
    end

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } bss_div_t;

    bss_div_t st;
    bss_div_t next_st;

    localparam logic [15:0] LAST = 16'(DIV - 1);

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        // restart aligns the first tick to a full period after start
        if (i_restart) begin
            next_st.cnt = 16'h0000;
        end else if (st.cnt == LAST) begin
            next_st.cnt  = 16'h0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;
endmodule : bss_tick_div

// file: test/bss_chk_sva.sv
module bss_chk_sva (
    input wire logic       I_REF_CLK,
    input wire logic       I_SYS_RST,
    input wire logic       I_START,
    input wire logic [1:0] I_RESOLUTION,
    input wire logic       I_RATIO_WR,
    input wire logic [1:0] I_SUPPLY_RATIO_SETTING,
    input wire logic       I_BRIDGE_MODE_SELECT,
    input wire logic       I_SDO_ENABLE,
    input wire logic       O_BRIDGE_SUPPLY,
    input wire logic       O_UPPER_STAGE,
    input wire logic       O_LOWER_STAGE,
    input wire logic       O_BUSY,
    input wire logic       O_DONE,
    input wire logic [3:0] O_UPPER_WIDTH,
    input wire logic [3:0] O_LOWER_WIDTH,
    input wire logic [1:0] O_RATIO,
    input wire logic       O_SDO_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);
    property p_wid;
        O_LOWER_WIDTH == O_UPPER_WIDTH - 4'h1 && O_UPPER_WIDTH >= 4'h6 && O_UPPER_WIDTH <= 4'h9;
    endproperty
    a_wid: assert property (p_wid) else $error("width pair");
    property p_go; I_START && !O_BUSY |=> O_UPPER_STAGE && O_BRIDGE_SUPPLY; endproperty
    a_go: assert property (p_go) else $error("start");
    property p_low; O_LOWER_STAGE |-> O_BRIDGE_SUPPLY == $past(I_BRIDGE_MODE_SELECT); endproperty
    a_low: assert property (p_low) else $error("lower supply");
    property p_res;
        I_START && !O_BUSY |=> O_UPPER_WIDTH == 4'h6 + {2'b00, $past(I_RESOLUTION)};
    endproperty
    a_res: assert property (p_res) else $error("resolution");
    property p_up; $rose(O_UPPER_STAGE) |-> O_UPPER_STAGE [*8]; endproperty
    a_up: assert property (p_up) else $error("upper short");
    property p_done; O_DONE |-> !O_BUSY && $past(O_LOWER_STAGE); endproperty
    a_done: assert property (p_done) else $error("done");
    property p_rat; I_RATIO_WR |=> O_RATIO == $past(I_SUPPLY_RATIO_SETTING); endproperty
    a_rat: assert property (p_rat) else $error("ratio");
    property p_mode;
        I_BRIDGE_MODE_SELECT && $past(I_BRIDGE_MODE_SELECT) && !$past(I_SYS_RST)
            |-> O_BRIDGE_SUPPLY;
    endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_oe; I_SDO_ENABLE |=> O_SDO_OE; endproperty
    a_oe: assert property (p_oe) else $error("oe");
endmodule : bss_chk_sva
bind bss_top bss_chk_sva chk_u (.*);

// file: test/bss_bridge_model.sv
module bss_bridge_model (
    input  wire logic i_clk,
    input  wire logic i_supply,
    output int        o_on_cycles
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    // one burst per conversion in switched mode, count restarts with each burst
    always @(posedge i_clk) begin
        last <= i_supply;
        if (i_supply) o_on_cycles <= (last ? o_on_cycles : 0) + 1;
    end
endmodule : bss_bridge_model

// file: test/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned DIV = 4;
    logic I_REF_CLK = 0, I_SYS_RST = 1, I_START = 0, I_RATIO_WR = 0;
    logic I_BRIDGE_MODE_SELECT = 0, I_SDO_DATA = 0, I_SDO_ENABLE = 0;
    logic [1:0] I_RESOLUTION = 2'h0, I_SUPPLY_RATIO_SETTING = 2'h0, O_RATIO, sdo_exp;
    logic O_BRIDGE_SUPPLY, O_UPPER_STAGE, O_LOWER_STAGE, O_BUSY, O_DONE, O_SDO, O_SDO_OE;
    logic [3:0] O_UPPER_WIDTH, O_LOWER_WIDTH;
    logic [31:0] lfsr = 32'h99325D80;
    int failures = 0, num_checks = 0, on_cycles, up, lo;
    bss_top #(.DIV(DIV)) dut_u (.*);
    bss_bridge_model br_u (.i_clk(I_REF_CLK), .i_supply(O_BRIDGE_SUPPLY), .o_on_cycles(on_cycles));
    always #50 I_REF_CLK = ~I_REF_CLK;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic finish_test;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        sdo_exp <= I_SYS_RST ? 2'h0 : {I_SDO_ENABLE, I_SDO_DATA};
    end
    always @(posedge I_REF_CLK) begin
        #1;
        lfsr = lfsr_next(lfsr);
        {I_SDO_ENABLE, I_SDO_DATA} = I_SYS_RST ? 2'h0 : lfsr[1:0];
    end
    always @(negedge I_REF_CLK) begin
        if (!I_SYS_RST) check({O_SDO_OE, O_SDO}, sdo_exp);
    end
    // a second start mid-run must be ignored, so lengths stay exact
    task automatic convert(input logic [1:0] res, input logic [1:0] rat, input logic mode);
        int n;
        int k;
        n = 1 << (res + 1 + rat);
        up = 0;
        lo = 0;
        {I_RATIO_WR, I_SUPPLY_RATIO_SETTING} = {1'b1, rat};
        {I_RESOLUTION, I_BRIDGE_MODE_SELECT} = {res, mode};
        @(posedge I_REF_CLK) #1;
        check(O_RATIO, rat);
        I_RATIO_WR = 0;
        I_START = 1;
        for (k = 0; k < 3000 && O_DONE !== 1'b1; k++) begin
            @(posedge I_REF_CLK) #1;
            I_START = (k == 6);
            up += O_UPPER_STAGE;
            lo += O_LOWER_STAGE;
            if (O_LOWER_STAGE) check(O_BRIDGE_SUPPLY, mode);
        end
        if (k == 3000) begin
            failures++;
            finish_test();
        end
        check(O_UPPER_WIDTH, res + 6);
        check(O_LOWER_WIDTH, res + 5);
        check((up + DIV / 2) / DIV, 2 * n);
        check((lo + DIV / 2) / DIV, res + 5);
        if (!mode) check((on_cycles + DIV / 2) / DIV, 2 * n);
        $display("test res=%0d ratio=%0d mode=%0d over", res, rat, mode);
    endtask : convert
    initial begin
        repeat (16) @(posedge I_REF_CLK);
        #1 I_SYS_RST = 0;
        check(O_RATIO, 2'h1);
        for (int i = 0; i < 16; i++) convert(i[3:2], i[1:0], 1'b0);
        convert(2'h1, 2'h3, 1'b1);
        @(posedge I_REF_CLK) #1;
        check(O_BRIDGE_SUPPLY, 1'b1);
        // reset in mid conversion, then a clean conversion right after release
        I_BRIDGE_MODE_SELECT = 0;
        I_START = 1;
        @(posedge I_REF_CLK) #1;
        I_START = 0;
        repeat (3) @(posedge I_REF_CLK) #1;
        check({O_UPPER_STAGE, O_BRIDGE_SUPPLY}, 2'h3);
        I_SYS_RST = 1;
        @(posedge I_REF_CLK) #1;
        check({O_BUSY, O_BRIDGE_SUPPLY, O_RATIO}, 4'h1);
        I_SYS_RST = 0;
        convert(2'h2, 2'h1, 1'b0);
        finish_test();
    end
endmodule : tb
